// file: src/ioeac_bus_eng.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// expander transaction sequencer: start, wait for bus done
// ****************************************
module ioeac_bus_eng #(
    parameter TMO = 250
) (
    input wire core_clk,
    input wire srst,
    input wire start,
    input wire bus_done,
    output reg busy_q,
    output reg fin_q
);
    // timeout counter so a silent bus never hangs the block
    reg [15:0] cnt_q;
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            busy_q <= 1'b0;
            fin_q <= 1'b0;
            cnt_q <= 16'h0000;
        end
        else
        begin
            fin_q <= 1'b0;
            if (!busy_q)
            begin
                if (start)
                begin
                    busy_q <= 1'b1;
                    cnt_q <= 16'h0000;
                end
            end
            else if (bus_done || cnt_q == TMO[15:0])
            begin
                // finishing pulse
                busy_q <= 1'b0;
                fin_q <= 1'b1;
            end
            else
                cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// file: src/ioeac_consts.vh
// Behaviour
// - pin value reads selected expander state
// - pin value writes dropped unless override set
// - override plus refresh sends written outputs
// - input bits never writable by software
// - refresh write launches expander bus transaction
// - refresh bit always reads zero
// - override drives outputs from written value
// - select field read-only, codes 0-4 valid
// - done set when refresh transaction finishes
// - done set when test-mode update finishes
// - done set when address write init finishes
// - each expander has own 7-bit address
`ifndef IOEAC_CONSTS_VH
`define IOEAC_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define IOEAC_OFS_INTF 12'h0430
`define IOEAC_OFS_ADDR0 12'h0434
`define IOEAC_OFS_ADDR1 12'h0438
`define IOEAC_OFS_IRQ_STS 12'h0440
`define IOEAC_OFS_IRQ_MASK 12'h0444
// ****************************************
// field positions
// ****************************************
`define IOEAC_PIN_MSB 15
`define IOEAC_REFRESH_BIT 24
`define IOEAC_OVR_BIT 25
`define IOEAC_SEL_LSB 26
`define IOEAC_SEL_MSB 29
`define IOEAC_DONE_BIT 31
// ****************************************
// reset values and counts
// ****************************************
`define IOEAC_RST_WORD 32'h0000_0000
`define IOEAC_NUM_EXP 5
`define IOEAC_BUS_TIME_NS 1000
`define IOEAC_CLK_NS 4
`endif

// file: src/ioeac_pin_mem.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// small per-expander pin value memory
// ****************************************
module ioeac_pin_mem #(
    parameter DEPTH = 5,
    parameter AW = 3
) (
    input wire core_clk,
    input wire srst,
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [15:0] wr_data,
    input wire [AW-1:0] rd_idx,
    output reg [15:0] rd_data_q
);
    // storage words, one per expander
    reg [15:0] mem_q [0:DEPTH-1];
    integer i;
    // write port and registered read port
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= 16'h0000;
            rd_data_q <= 16'h0000;
        end
        else
        begin
            if (wr_en)
                mem_q[wr_idx] <= wr_data;
            rd_data_q <= mem_q[rd_idx];
        end
    end
endmodule
`default_nettype wire

// file: src/ioeac_top.v
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ioeac_consts.vh"
// ****************************************
// expander access control register bank, ahb-lite slave
// ****************************************
module ioeac_top #(
    parameter [3:0] SEL_CODE = 4'h0,
    parameter [15:0] INPUT_MASK = 16'h00FF,
    parameter BUS_TMO = (`IOEAC_BUS_TIME_NS * 100) / `IOEAC_CLK_NS
) (
    input wire core_clk,
    input wire srst,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [15:0] core_out_val,
    input wire [15:0] exp_in_val,
    input wire bus_done,
    output reg bus_start_q,
    output reg [6:0] bus_addr_q,
    output reg [15:0] bus_out_val_q,
    output reg irq_q
);
    // ****************************************
    // ahb address phase capture
    // ****************************************
    reg ph_wr_q;
    reg ph_rd_q;
    reg [11:0] ph_addr_q;
    wire take = hsel && hready && htrans[1];
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            ph_addr_q <= 12'h000;
        end
        else
        begin
            ph_wr_q <= take && hwrite;
            ph_rd_q <= take && !hwrite;
            if (take)
                ph_addr_q <= haddr;
        end
    end
    // decoded write strobes in data phase
    wire wr_intf = ph_wr_q && ph_addr_q == `IOEAC_OFS_INTF;
    wire wr_a0 = ph_wr_q && ph_addr_q == `IOEAC_OFS_ADDR0;
    wire wr_a1 = ph_wr_q && ph_addr_q == `IOEAC_OFS_ADDR1;
    wire wr_sts = ph_wr_q && ph_addr_q == `IOEAC_OFS_IRQ_STS;
    wire wr_msk = ph_wr_q && ph_addr_q == `IOEAC_OFS_IRQ_MASK;
    // ****************************************
    // control state
    // ****************************************
    reg ovr_q; // test override
    reg done_q; // completion flag
    reg [31:0] addr0_q;
    reg [7:0] addr1_q;
    reg irq_sts_q;
    reg irq_msk_q;
    reg [1:0] pend_q; // 1 refresh, 2 test update, 3 init
    reg [15:0] test_val_q; // software outputs for test mode
    wire eng_busy;
    wire eng_fin;
    wire [15:0] mem_rd;
    reg [15:0] cap_in_q; // expander inputs latched with the done pulse
    // next address words: a launch caused by an address write must use the new field
    wire [31:0] addr0_d = wr_a0 ? (hwdata & 32'hFEFE_FEFE) : addr0_q;
    wire [7:0] addr1_d = wr_a1 ? (hwdata[7:0] & 8'hFE) : addr1_q;
    // expander code clipped to the real range
    wire [2:0] sel_idx = (SEL_CODE > 4'h4) ? 3'h4 : SEL_CODE[2:0];
    // bus address field of the selected expander
    function [6:0] pick_addr;
        input [2:0] idx;
        input [31:0] a0;
        input [7:0] a1;
        begin
            case (idx)
                3'h0: pick_addr = a0[7:1];
                3'h1: pick_addr = a0[15:9];
                3'h2: pick_addr = a0[23:17];
                3'h3: pick_addr = a0[31:25];
                default: pick_addr = a1[7:1];
            endcase
        end
    endfunction
    // software pin write, only output bits and only in override
    wire pin_wr = wr_intf && hwdata[`IOEAC_OVR_BIT] && ovr_q;
    wire [15:0] pin_wdata = (hwdata[15:0] & ~INPUT_MASK) | (test_val_q & INPUT_MASK);
    wire refresh_wr = wr_intf && hwdata[`IOEAC_REFRESH_BIT];
    wire addr_wr = wr_a0 || wr_a1;
    wire launch = !eng_busy && (refresh_wr || pin_wr || addr_wr);
    // output values: written ones in test mode, else core ones
    wire [15:0] out_sel = ovr_q ? test_val_q : core_out_val;
    // ****************************************
    // register updates
    // ****************************************
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            ovr_q <= 1'b0;
            done_q <= 1'b0;
            addr0_q <= `IOEAC_RST_WORD;
            addr1_q <= 8'h00;
            irq_sts_q <= 1'b0;
            irq_msk_q <= 1'b0;
            pend_q <= 2'h0;
            test_val_q <= 16'h0000;
            bus_start_q <= 1'b0;
            bus_addr_q <= 7'h00;
            bus_out_val_q <= 16'h0000;
            irq_q <= 1'b0;
        end
        else
        begin
            if (wr_intf)
                ovr_q <= hwdata[`IOEAC_OVR_BIT];
            if (pin_wr)
                test_val_q <= pin_wdata;
            // address fields keep bit positions, reserved bits zero
            if (wr_a0)
                addr0_q <= hwdata & 32'hFEFE_FEFE;
            if (wr_a1)
                addr1_q <= hwdata[7:0] & 8'hFE;
            bus_start_q <= launch;
            // clear first, so a launch in the finishing cycle keeps its cause
            if (eng_fin)
                pend_q <= 2'h0;
            if (launch)
            begin
                pend_q <= refresh_wr ? 2'h1 : (pin_wr ? 2'h2 : 2'h3);
                bus_addr_q <= pick_addr(sel_idx, addr0_d, addr1_d);
                bus_out_val_q <= pin_wr ? pin_wdata : out_sel;
            end
            // set wins over write-one clear
            if (eng_fin && pend_q != 2'h0)
                done_q <= 1'b1;
            else if (wr_intf && hwdata[`IOEAC_DONE_BIT])
                done_q <= 1'b0;
            if (eng_fin && pend_q != 2'h0)
                irq_sts_q <= 1'b1;
            else if (wr_sts && hwdata[0])
                irq_sts_q <= 1'b0;
            if (wr_msk)
                irq_msk_q <= hwdata[0];
            irq_q <= irq_sts_q && irq_msk_q;
        end
    end
    // ****************************************
    // cached pin values, refreshed at transaction end
    // ****************************************
    // expander inputs only hold with the done pulse, so keep a copy
    always @(posedge core_clk)
    begin
        if (srst)
            cap_in_q <= 16'h0000;
        else if (bus_done)
            cap_in_q <= exp_in_val;
    end
    wire [15:0] fetched = (cap_in_q & INPUT_MASK) | (bus_out_val_q & ~INPUT_MASK);
    ioeac_pin_mem #(
        .DEPTH(`IOEAC_NUM_EXP),
        .AW(3)
    ) u_mem (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(eng_fin && pend_q != 2'h0),
        .wr_idx(sel_idx),
        .wr_data(fetched),
        .rd_idx(sel_idx),
        .rd_data_q(mem_rd)
    );
    ioeac_bus_eng #(
        .TMO(BUS_TMO)
    ) u_eng (
        .core_clk(core_clk),
        .srst(srst),
        .start(launch),
        .bus_done(bus_done),
        .busy_q(eng_busy),
        .fin_q(eng_fin)
    );
    // ****************************************
    // read mux and response, zero wait
    // ****************************************
    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h0000_0000;
        case (haddr)
            `IOEAC_OFS_INTF: rd_d = {done_q, 1'b0, SEL_CODE, ovr_q, 1'b0, 8'h00, mem_rd};
            `IOEAC_OFS_ADDR0: rd_d = addr0_q;
            `IOEAC_OFS_ADDR1: rd_d = {24'h00_0000, addr1_q};
            `IOEAC_OFS_IRQ_STS: rd_d = {31'h0000_0000, irq_sts_q};
            `IOEAC_OFS_IRQ_MASK: rd_d = {31'h0000_0000, irq_msk_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite)
                hrdata <= rd_d;
        end
    end
endmodule
`default_nettype wire

// file: tb/ioeac_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// register port checker
// ****
module ioeac_chk #(
    parameter [3:0] SEL_CODE = 4'h0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic bus_done,
    input wire logic bus_start_q,
    input wire logic [15:0] bus_out_val_q
);
    logic ap; // an address phase is taken
    logic wr_q, wi_q, rd_q, ru_q, dn_q, busy_q;
    assign ap = hsel & hready & htrans[1];
    // data-phase markers; busy tracks the expander bus from the ports
    always_ff @(posedge core_clk)
    begin
        wr_q <= ap & hwrite & (haddr[11:4] == 8'h43);
        wi_q <= ap & hwrite & (haddr == 12'h430);
        rd_q <= ap & !hwrite & (haddr == 12'h430);
        ru_q <= ap & !hwrite & (haddr == 12'h43c);
        dn_q <= bus_done;
        busy_q <= srst ? 1'b0 : bus_start_q | (busy_q & !bus_done);
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    chk_bus_okay: assert property (hresp == 1'b0 && hreadyout) else $error("slave not ready");
    chk_start_pulse: assert property (bus_start_q |=> !bus_start_q) else $error("long start");
    chk_refresh_go: assert property (wi_q && hwdata[24] && !busy_q && !bus_start_q && !dn_q
        && !bus_done |=> bus_start_q) else $error("refresh not launched");
    chk_start_cause: assert property (bus_start_q |-> $past(wr_q)) else $error("stray start");
    chk_rsvd_zero: assert property (rd_q |-> (hrdata & 32'h41ff_0000) == 32'h0) else $error("rsvd");
    chk_sel_field: assert property (rd_q |-> hrdata[29:26] == SEL_CODE) else $error("select");
    chk_unmap_zero: assert property (ru_q |-> hrdata == 32'h0000_0000) else $error("unmapped");
    chk_out_hold: assert property (busy_q && !bus_start_q |-> $stable(bus_out_val_q))
        else $error("outputs moved mid transaction");
endmodule
bind ioeac_top ioeac_chk #(.SEL_CODE(SEL_CODE)) u_chk (.core_clk(core_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bus_done(bus_done), .bus_start_q(bus_start_q), .bus_out_val_q(bus_out_val_q));
`default_nettype wire

// file: tb/ioeac_exp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// expander chip on the bus: answers after a short or long time
// ****
module ioeac_exp_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic bus_start_q,
    input wire logic slow,
    input wire logic [15:0] pins,
    output logic bus_done,
    output logic [15:0] exp_in_val
);
    int cnt_q; // cycles left in the transaction
    // stale input data toggles so nothing can lean on it
    always @(posedge core_clk)
    begin
        bus_done <= 1'b0;
        exp_in_val <= ~exp_in_val;
        if (srst)
        begin
            cnt_q <= 0;
            exp_in_val <= 16'h0000;
        end
        else if (bus_start_q)
            cnt_q <= slow ? 15 : 2;
        else if (cnt_q == 1)
        begin
            bus_done <= 1'b1;
            exp_in_val <= pins;
            cnt_q <= 0;
        end
        else if (cnt_q > 1)
            cnt_q <= cnt_q - 1;
    end
endmodule
`default_nettype wire

// file: tb/test_io_expander_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_io_expander_access_control;
    localparam logic [15:0] IM = 16'h00ff; // low byte are inputs
    localparam logic [3:0] SEL = 4'h2;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic slow = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [15:0] cov = 16'h0000;
    logic [15:0] pins = 16'h0000;
    logic [31:0] hrdata, r, d;
    logic hreadyout, hresp, bus_done, bus_start_q, irq_q, ovr_m, done_m;
    logic [6:0] bus_addr_q;
    logic [15:0] exp_in_val, bus_out_val_q, cache;
    int error_cnt, tests_run, starts, starts_m, k;
    int seed = 32'hc35b_b560;
    ioeac_top #(.SEL_CODE(SEL), .INPUT_MASK(IM), .BUS_TMO(40)) dut (.core_clk(core_clk),
        .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_out_val(cov), .exp_in_val(exp_in_val),
        .bus_done(bus_done), .bus_start_q(bus_start_q), .bus_addr_q(bus_addr_q),
        .bus_out_val_q(bus_out_val_q), .irq_q(irq_q));
    ioeac_exp_model u_exp (.core_clk(core_clk), .srst(srst), .bus_start_q(bus_start_q),
        .slow(slow), .pins(pins), .bus_done(bus_done), .exp_in_val(exp_in_val));
    initial
        forever #2 core_clk = ~core_clk;
    // count launches seen at the bus side
    always @(posedge core_clk)
        if (!srst && bus_start_q === 1'b1)
            starts <= starts + 1;
    // ****
    // helpers
    // ****
    function automatic logic [31:0] word();
        return {done_m, 1'b0, SEL, ovr_m, 9'h000, cache};
    endfunction
    task automatic finish_test();
        $display("compares %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // one single transfer; holds each phase until hready
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] v);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= v;
        do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
        r = hrdata;
        chk("hready", 0, n >= 50);
        if (n >= 50)
            finish_test();
    endtask
    task automatic rdc(input logic [31:0] e);
        xfer(12'h430, 1'b0, 32'h0000_0000);
        chk("intf", e, r);
    endtask
    task automatic op(input logic [31:0] v);
        xfer(12'h430, 1'b1, v);
        starts_m++;
        k = 0;
        while (irq_q !== 1'b1 && ++k < 100)
            @(posedge core_clk);
        chk("irq", 1, irq_q);
        if (k >= 100)
            finish_test();
    endtask
    task automatic ack();
        xfer(12'h440, 1'b1, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        chk("irq", 0, irq_q);
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        {cache, ovr_m, done_m} = '0;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rdc(word());
        xfer(12'h430, 1'b1, $random(seed) & 32'h0000_ffff);
        rdc(word());
        xfer(12'h43c, 1'b1, 32'hffff_ffff);
        xfer(12'h43c, 1'b0, 32'h0000_0000);
        chk("unmapped", 0, r);
        d = $random(seed) & 32'h00fe_0000;
        xfer(12'h434, 1'b1, d);
        starts_m++;
        k = 0;
        do xfer(12'h430, 1'b0, 32'h0000_0000); while (r[31] !== 1'b1 && ++k < 100);
        chk("done", 1, r[31]);
        if (k >= 100)
            finish_test();
        done_m = 1'b1;
        chk("irq", 0, irq_q);
        chk("addr", d[23:17], bus_addr_q);
        xfer(12'h444, 1'b1, 32'h0000_0001);
        op(32'h0000_0000);
        starts_m--;
        ack();
        for (int i = 0; i < 2; i++)
        begin
            slow <= i[0];
            pins <= $random(seed);
            cov <= $random(seed);
            xfer(12'h430, 1'b1, 32'h8000_0000);
            op(32'h0100_0000);
            chk("outv", cov & ~IM, bus_out_val_q & ~IM);
            cache = (pins & IM) | (cov & ~IM);
            rdc(word());
            ack();
        end
        d = $random(seed);
        xfer(12'h430, 1'b1, {16'h0200, d[15:0]});
        ovr_m = 1'b1;
        rdc(word());
        for (int i = 0; i < 2; i++)
        begin
            d = $random(seed);
            op({7'h01, ~i[0], 8'h00, d[15:0]});
            chk("outv", d[15:0] & ~IM, bus_out_val_q & ~IM);
            cache = (pins & IM) | (d[15:0] & ~IM);
            rdc(word());
            ack();
        end
        xfer(12'h430, 1'b1, 32'h8000_0000);
        {done_m, ovr_m} = 2'b00;
        rdc(word());
        chk("starts", starts_m, starts);
        finish_test();
    end
endmodule
`default_nettype wire
